/* File: uabr_top.sv */
// uabr_top: baud rate generator and serial receiver with Avalon-MM registers
// How it works
// [R1] baud source is the serial clock pin, core clock, or core clock over eight
// [R2] asynchronous: selected clock over sixteen times divisor; zero divisor stops it
// [R3] synchronous internal: selected clock over divisor; zero divisor stops it
// [R4] synchronous with source upper bit set: serial clock pin used directly, undivided
// [R5] external clock levels exceed one core period, frequency under 40% core
// [R6] mode bit 7 picks asynchronous (0) or synchronous (1) operation
// [R7] asynchronous start accepted only after more than 7 low samples
// [R8] first bit sampled 24 ticks after start edge, then every 16
// [R9] synchronous: sample on each bit clock edge, low marks a start
// [R10] finished character goes to holding register, ready flag set after stop
// [R11] new character before holding register is read sets overrun flag
// [R12] parity over data bits per setting; mismatch sets parity error flag
// [R13] stop bit low with any data bit high sets framing error flag
// [R14] character length programmable from 5 to 9 data bits
// [R15] receive transfer channel moves characters without software help
// [R16] break: whole character low sets break flag at the stop sample
// [R17] interrupt asserted while any status flag and its mask bit are set
// [R18] reset restarts hunting, clears divider and all status flags
`timescale 1ns/100ps
module uabr_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rxd,
   input  wire logic        sck,
   output logic             irq,
   output logic             rx_xfer_req,
   input  wire logic        rx_xfer_ack,
   output logic [8:0]       rx_xfer_data
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] data_bits(input logic [2:0] code);
      logic [2:0] c;
      c = (code > uabr_pkg::MAX_LEN_CODE) ? uabr_pkg::MAX_LEN_CODE : code;
      data_bits = 4'(uabr_pkg::MIN_DATA_BITS) + {1'b0, c};
   endfunction : data_bits

   function automatic logic exp_parity(input logic [8:0] d, input logic [2:0] p);
      case (p)
         uabr_pkg::PAR_EVEN:  exp_parity = ^d;
         uabr_pkg::PAR_ODD:   exp_parity = ~(^d);
         uabr_pkg::PAR_SPACE: exp_parity = 1'b0;
         uabr_pkg::PAR_MARK:  exp_parity = 1'b1;
         default:             exp_parity = 1'b0;
      endcase
   endfunction : exp_parity

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] pins_s;
   logic       sck_d_q;

   uabr_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .pin_in   ({sck, rxd}),
      .pin_sync (pins_s)
   );

   wire rx_s     = pins_s[0];
   wire sck_s    = pins_s[1];
   wire sck_rise = sck_s & ~sck_d_q;

   // ------------------------------------------------------------
   // registers and bus decode
   // ------------------------------------------------------------
   logic [uabr_pkg::MODE_W-1:0] mode_q;
   logic [15:0]                 divisor_q;
   logic [uabr_pkg::ST_W-1:0]   stat_q;
   logic [uabr_pkg::ST_W-1:0]   mask_q;
   logic [8:0]                  hold_q;
   logic                        unread_q;

   wire       bus_ack  = (avs_read | avs_write) & ~avs_waitrequest;
   wire       wr_ack   = bus_ack & avs_write;
   wire       rd_ack   = bus_ack & avs_read;
   wire       wr_mode  = wr_ack & (avs_address == uabr_pkg::OFS_MODE);
   wire       wr_div   = wr_ack & (avs_address == uabr_pkg::OFS_DIVISOR);
   wire       wr_ien   = wr_ack & (avs_address == uabr_pkg::OFS_IRQ_EN);
   wire       wr_idis  = wr_ack & (avs_address == uabr_pkg::OFS_IRQ_DIS);
   wire       rd_stat  = rd_ack & (avs_address == uabr_pkg::OFS_STATUS);
   wire       rd_hold  = rd_ack & (avs_address == uabr_pkg::OFS_HOLDING);
   wire       consume  = rd_hold | rx_xfer_ack;

   // [R6] mode select
   wire       sync_md  = mode_q[uabr_pkg::MODE_SYNC_BIT];
   wire [1:0] csel     = mode_q[uabr_pkg::MODE_CSEL_LSB +: 2];
   wire [2:0] len_code = mode_q[uabr_pkg::MODE_LEN_LSB +: 3];
   wire [2:0] par_set  = mode_q[uabr_pkg::MODE_PAR_LSB +: 3];
   wire       par_en   = ~par_set[2];

   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address)
         uabr_pkg::OFS_MODE:     rd_mux = {21'h0, mode_q};
         uabr_pkg::OFS_DIVISOR:  rd_mux = {16'h0, divisor_q};
         uabr_pkg::OFS_STATUS:   rd_mux = {27'h0, stat_q};
         uabr_pkg::OFS_HOLDING:  rd_mux = {23'h0, hold_q};
         uabr_pkg::OFS_IRQ_MASK: rd_mux = {27'h0, mask_q};
         default:                rd_mux = 32'h0;
      endcase
   end

   // one wait cycle, then a single ready cycle per request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         avs_readdata    <= rd_mux;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q    <= uabr_pkg::MODE_RST;
         divisor_q <= uabr_pkg::DIV_RST;
      end else begin
         if (wr_mode)
            mode_q <= avs_writedata[uabr_pkg::MODE_W-1:0];
         if (wr_div)
            divisor_q <= avs_writedata[15:0];
      end
   end

   // ------------------------------------------------------------
   // baud rate generator
   // ------------------------------------------------------------
   logic [2:0]  pre_q;
   logic [15:0] div_cnt_q;

   // [R1] source select
   wire pre_en  = (pre_q == uabr_pkg::PRESCALE_LAST);
   wire sel_en  = csel[1] ? sck_rise : (csel[0] ? pre_en : 1'b1);
   // [R2] zero divisor gives no tick
   wire div_hit = sel_en & (divisor_q != 16'h0) & (div_cnt_q >= divisor_q - 16'h1);
   // [R4] undivided pin clock
   wire ext_bit = sync_md & csel[1];
   // [R3] async: 16x sample tick; sync: bit tick
   wire rx_tick = ext_bit ? sck_rise : div_hit;

   // [R18] divider restarts from zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_q     <= 3'h0;
         div_cnt_q <= 16'h0;
         sck_d_q   <= 1'b1;
      end else begin
         pre_q   <= pre_q + 3'h1;
         sck_d_q <= sck_s;
         if (div_hit | wr_div)
            div_cnt_q <= 16'h0;
         else if (sel_en)
            div_cnt_q <= div_cnt_q + 16'h1;
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   uabr_pkg::uabr_state_t state_q;
   logic [2:0]  low_q;
   logic [4:0]  wait_q;
   logic [3:0]  idx_q;
   logic [1:0]  hi_q;
   logic [uabr_pkg::RX_STORE_W-1:0] bits_q;

   // [R14] five to nine bits
   wire [3:0] n_data   = data_bits(len_code);
   wire [3:0] last_idx = n_data + {3'h0, par_en};
   wire [8:0] dmask    = 9'(({1'b0, 9'h1FF} >> (4'h9 - n_data)));
   wire [8:0] rx_data  = bits_q[8:0] & dmask;
   // [R8] sample near mid-bit
   wire sample   = (state_q == uabr_pkg::UABR_DATA) & rx_tick & (sync_md | (wait_q == 5'h0));
   wire done     = sample & (idx_q == last_idx);
   // [R7] start qualified by low run
   wire async_st = ~sync_md & rx_tick & ~rx_s & (low_q == uabr_pkg::START_LOW_MIN);
   // [R9] sync start on one low sample
   wire sync_st  = sync_md & rx_tick & ~rx_s;
   wire go_data  = (state_q == uabr_pkg::UABR_HUNT) & (async_st | sync_st);
   wire par_bit  = bits_q[n_data];
   // [R12] parity check
   wire par_bad  = done & par_en & (par_bit != exp_parity(rx_data, par_set));
   // [R13] framing check
   wire frm_bad  = done & ~rx_s & (|rx_data);
   // [R16] all low incl. parity and stop
   wire brk_det  = done & ~rx_s & ~(|rx_data) & ~(par_en & par_bit);
   wire [1:0] hi_need = sync_md ? uabr_pkg::BRK_END_SYNC : uabr_pkg::BRK_END_ASYNC;
   wire brk_end  = (state_q == uabr_pkg::UABR_BRK) & rx_tick & rx_s & (hi_q + 2'h1 >= hi_need);

   // [R18] reset returns to hunting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= uabr_pkg::UABR_HUNT;
         low_q   <= 3'h0;
         wait_q  <= 5'h0;
         idx_q   <= 4'h0;
         hi_q    <= 2'h0;
         bits_q  <= '0;
      end else begin
         case (state_q)
            uabr_pkg::UABR_HUNT: begin
               if (go_data) begin
                  state_q <= uabr_pkg::UABR_DATA;
                  wait_q  <= uabr_pkg::FIRST_WAIT;
                  idx_q   <= 4'h0;
                  bits_q  <= '0;
                  low_q   <= 3'h0;
               end else if (rx_tick)
                  low_q <= rx_s ? 3'h0 : low_q + 3'h1;
            end
            uabr_pkg::UABR_DATA: begin
               if (rx_tick & ~sync_md)
                  wait_q <= (wait_q == 5'h0) ? uabr_pkg::BIT_WAIT : wait_q - 5'h1;
               if (sample) begin
                  bits_q[idx_q] <= rx_s;
                  idx_q         <= idx_q + 4'h1;
               end
               if (done) begin
                  hi_q    <= 2'h0;
                  state_q <= brk_det ? uabr_pkg::UABR_BRK : uabr_pkg::UABR_HUNT;
               end
            end
            uabr_pkg::UABR_BRK: begin
               // line must return high before a new start can be hunted
               if (brk_end)
                  state_q <= uabr_pkg::UABR_HUNT;
               else if (rx_tick)
                  hi_q <= rx_s ? hi_q + 2'h1 : 2'h0;
            end
            default: state_q <= uabr_pkg::UABR_HUNT;
         endcase
      end
   end

   // ------------------------------------------------------------
   // holding register, status flags and interrupt
   // ------------------------------------------------------------
   logic [uabr_pkg::ST_W-1:0] ev_set;
   always_comb begin
      ev_set = '0;
      // [R10] ready after stop sample
      ev_set[uabr_pkg::ST_RDY_BIT] = done;
      // [R11] overrun on unread holding data
      ev_set[uabr_pkg::ST_OVR_BIT] = done & unread_q & ~consume;
      ev_set[uabr_pkg::ST_PAR_BIT] = par_bad;
      ev_set[uabr_pkg::ST_FRM_BIT] = frm_bad;
      ev_set[uabr_pkg::ST_BRK_BIT] = brk_det | brk_end;
   end

   // a status read clears only the bits it returned, so an event in its wait cycle survives
   wire [uabr_pkg::ST_W-1:0] st_rd  = {uabr_pkg::ST_W{rd_stat}} & avs_readdata[uabr_pkg::ST_W-1:0];
   wire [uabr_pkg::ST_W-1:0] st_clr = st_rd | {{(uabr_pkg::ST_W-1){1'b0}}, consume};

   // events win over a clearing read in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_q   <= uabr_pkg::ST_RST;
         mask_q   <= uabr_pkg::ST_RST;
         hold_q   <= 9'h0;
         unread_q <= 1'b0;
         irq      <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~st_clr) | ev_set;
         // [R17] enable and disable writes
         if (wr_ien)
            mask_q <= mask_q | avs_writedata[uabr_pkg::ST_W-1:0];
         else if (wr_idis)
            mask_q <= mask_q & ~avs_writedata[uabr_pkg::ST_W-1:0];
         // [R10] transfer to holding register
         if (done)
            hold_q <= rx_data;
         unread_q <= done | (unread_q & ~consume);
         // [R17] interrupt level
         irq <= |(stat_q & mask_q);
      end
   end

   // [R15] receive transfer channel
   assign rx_xfer_req  = unread_q;
   assign rx_xfer_data = hold_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PRESCALE: assert property (pre_en |=> !pre_en [*7] ##1 pre_en) // [R1]
      else $error("core clock over eight enable period wrong");

   AST_CORE_SRC: assert property ((!csel[1] && divisor_q == 16'h1) |-> rx_tick == (!csel[0] || pre_en)) // [R1]
      else $error("internal source with divisor one must tick on every selected clock");

   AST_DIV_ZERO: assert property ((divisor_q == 16'h0 && !ext_bit) |-> !rx_tick) // [R2]
      else $error("zero divisor must stop the bit rate clock");

   AST_DIV_GAP: assert property ((div_hit && divisor_q > 16'h1 && !wr_div) |=> !div_hit) // [R3]
      else $error("divided clock ticked on adjacent cycles");

   AST_EXT_PIN: assert property ((ext_bit && sck_rise) |-> rx_tick) // [R4]
      else $error("external serial clock edge not used directly");

   AST_START_FILTER: assert property ((state_q == uabr_pkg::UABR_HUNT && !sync_md && rx_tick && rx_s)
                                      |=> state_q == uabr_pkg::UABR_HUNT && low_q == 3'h0) // [R7]
      else $error("high sample did not restart the start search");

   AST_FIRST_WAIT: assert property ((go_data && !sync_md) |=> wait_q == 5'h10) // [R8]
      else $error("first data sample not placed 24 ticks after start edge");

   AST_SYNC_START: assert property ((state_q == uabr_pkg::UABR_HUNT && sync_md && rx_tick && !rx_s)
                                    |=> state_q == uabr_pkg::UABR_DATA) // [R9]
      else $error("synchronous low sample not taken as start");

   AST_READY: assert property (done |=> stat_q[uabr_pkg::ST_RDY_BIT] && unread_q) // [R10]
      else $error("ready flag not set after stop bit");

   AST_OVERRUN: assert property ((done && unread_q && !consume) |=> stat_q[uabr_pkg::ST_OVR_BIT]) // [R11]
      else $error("overrun flag missed on unread holding data");

   AST_FRAME: assert property ((done && !rx_s && (|rx_data)) |=> stat_q[uabr_pkg::ST_FRM_BIT]) // [R13]
      else $error("framing error not flagged");

   AST_LEN_RANGE: assert property (n_data >= 4'h5 && n_data <= 4'h9) // [R14]
      else $error("character length outside five to nine bits");

   AST_XFER_TAKEN: assert property ((rx_xfer_ack && !done) |=> !rx_xfer_req) // [R15]
      else $error("acknowledged character still requested");

   AST_BREAK: assert property (brk_det |=> stat_q[uabr_pkg::ST_BRK_BIT] && state_q == uabr_pkg::UABR_BRK) // [R16]
      else $error("break not flagged on all-low character");

   AST_IRQ: assert property ((|(stat_q & mask_q)) |=> irq) // [R17]
      else $error("interrupt not raised for masked-in flag");

   AST_BUS_ACK: assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest) // bus read handshake
      else $error("register access not answered after one wait cycle");
endmodule : uabr_top

/* File: uabr_pkg.sv */
// uabr_pkg: constants of the baud generator and receiver block
package uabr_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses, word aligned)
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_MODE     = 5'h00;
   localparam logic [4:0] OFS_DIVISOR  = 5'h04;
   localparam logic [4:0] OFS_STATUS   = 5'h08;
   localparam logic [4:0] OFS_HOLDING  = 5'h0C;
   localparam logic [4:0] OFS_IRQ_EN   = 5'h10;
   localparam logic [4:0] OFS_IRQ_DIS  = 5'h14;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h18;
   // ------------------------------------------------------------
   // mode register fields
   // ------------------------------------------------------------
   localparam int MODE_W        = 11;
   localparam int MODE_LEN_LSB  = 0;
   localparam int MODE_CSEL_LSB = 4;
   localparam int MODE_SYNC_BIT = 7;
   localparam int MODE_PAR_LSB  = 8;
   localparam logic [MODE_W-1:0] MODE_RST = 11'h400;
   localparam logic [15:0]       DIV_RST  = 16'h0000;
   // ------------------------------------------------------------
   // status bits, shared by status and mask registers
   // ------------------------------------------------------------
   localparam int ST_W       = 5;
   localparam int ST_RDY_BIT = 0;
   localparam int ST_OVR_BIT = 1;
   localparam int ST_PAR_BIT = 2;
   localparam int ST_FRM_BIT = 3;
   localparam int ST_BRK_BIT = 4;
   localparam logic [ST_W-1:0] ST_RST = 5'h00;
   // ------------------------------------------------------------
   // parity settings
   // ------------------------------------------------------------
   localparam logic [2:0] PAR_EVEN  = 3'h0;
   localparam logic [2:0] PAR_ODD   = 3'h1;
   localparam logic [2:0] PAR_SPACE = 3'h2;
   localparam logic [2:0] PAR_MARK  = 3'h3;
   // ------------------------------------------------------------
   // timing counts, in sample ticks or core cycles
   // ------------------------------------------------------------
   localparam logic [2:0] PRESCALE_LAST = 3'h7;
   localparam logic [2:0] START_LOW_MIN = 3'h7;
   localparam logic [4:0] FIRST_WAIT    = 5'h10;
   localparam logic [4:0] BIT_WAIT      = 5'h0F;
   localparam logic [1:0] BRK_END_ASYNC = 2'h2;
   localparam logic [1:0] BRK_END_SYNC  = 2'h1;
   localparam int         MIN_DATA_BITS = 5;
   localparam logic [2:0] MAX_LEN_CODE  = 3'h4;
   localparam int         RX_STORE_W    = 11;
   typedef enum logic [1:0] {UABR_HUNT, UABR_DATA, UABR_BRK} uabr_state_t;
endpackage : uabr_pkg

/* File: uabr_sync.sv */
// uabr_sync: two flip-flop synchroniser for the serial pins
`timescale 1ns/100ps
module uabr_sync (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] pin_in,
   output logic [1:0]      pin_sync
);
   logic [1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q   <= 2'h3;
         pin_sync <= 2'h3;
      end else begin
         meta_q   <= pin_in;
         pin_sync <= meta_q;
      end
   end
endmodule : uabr_sync

/* File: uabr_tx_model.sv */
// uabr_tx_model: remote serial transmitter driving the receive pin and serial clock
`timescale 1ns/100ps
module uabr_tx_model (
   input  wire logic clk,
   output logic      rxd,
   output logic      sck
);
   // line idles high and the clock stands low outside frames
   initial begin
      rxd = 1'b1;
      sck = 1'b0;
   end
   // ------------------------------------------------------------
   // one bit on the line, bc core cycles long
   // ------------------------------------------------------------
   task automatic put_bit(input logic b, input int bc, input bit ext);
      @(posedge clk);
      rxd <= b;
      if (ext) begin
         // slow serial clock
         // levels of bc/2 core cycles; bc of 8 keeps the rate at an eighth of core
         repeat (bc / 2 - 1) @(posedge clk);
         sck <= 1'b1;
         repeat (bc / 2) @(posedge clk);
         sck <= 1'b0;
      end else begin
         repeat (bc - 1) @(posedge clk);
      end
   endtask : put_bit
   // ------------------------------------------------------------
   // whole character: start, data lsb first, parity, stop, idle gap
   // ------------------------------------------------------------
   task automatic send(input logic [8:0] d, input int nb, input logic [2:0] par, input bit bad_par,
                       input bit stop, input int bc, input bit ext);
      logic p;
      p = (par == 3'h0) ? ^d : (par == 3'h1) ? ~^d : (par == 3'h3);
      p = p ^ bad_par;
      put_bit(1'b0, bc, ext);
      for (int i = 0; i < nb; i++) begin
         put_bit(d[i], bc, ext);
      end
      if (par < 3'h4) begin
         put_bit(p, bc, ext);
      end
      put_bit(stop, bc, ext);
      // gap long enough for a break end to be seen before the next step
      put_bit(1'b1, 2 * bc, 1'b0);
   endtask : send
   // short low pulse, too short to be a start bit
   task automatic low_pulse(input int n);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (n) @(posedge clk);
      rxd <= 1'b1;
   endtask : low_pulse
endmodule : uabr_tx_model

/* File: uabr_top_tb.sv */
// uabr_top_tb: self-checking testbench of the baud generator and receiver
`timescale 1ns/100ps
module uabr_top_tb;
   typedef struct packed {
      logic [2:0] len;
      logic [2:0] par;
      logic [8:0] dat;
      logic       bad;
      logic       stp;
      logic [4:0] st;
      logic [4:0] stm;
   } uabr_row_t;
   logic        clk;
   logic        rst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rxd;
   logic        sck;
   logic        irq;
   logic        rx_xfer_req;
   logic        rx_xfer_ack;
   logic [8:0]  rx_xfer_data;
   int          err_total;
   int          n_tests;
   uabr_row_t   rows [8];

   uabr_top u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxd(rxd), .sck(sck), .irq(irq),
      .rx_xfer_req(rx_xfer_req), .rx_xfer_ack(rx_xfer_ack), .rx_xfer_data(rx_xfer_data));
   uabr_tx_model u_tx (.clk(clk), .rxd(rxd), .sck(sck));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      cmp(32'(n), 32'h2);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      cmp(q & m, exp & m);
   endtask : rdc
   task automatic wait_hi(input bit use_irq);
      int n;
      n = 0;
      while ((use_irq ? irq : rx_xfer_req) !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      cmp(32'(n < 4000), 32'h1);
   endtask : wait_hi
   function automatic logic [31:0] mode(input logic [2:0] len, input logic [2:0] par, input logic [1:0] cs,
                                         input logic sy);
      return {21'h0, par, sy, 1'b0, cs, 1'b0, len};
   endfunction : mode
   // unmapped write must leave no trace
   task automatic chk_regs();
      wr(5'h1C, 32'hFFFF_FFFF);
      rdc(uabr_pkg::OFS_MODE, {21'h0, uabr_pkg::MODE_RST}, 32'hFFFF_FFFF);
      rdc(uabr_pkg::OFS_DIVISOR, {16'h0, uabr_pkg::DIV_RST}, 32'hFFFF_FFFF);
      rdc(uabr_pkg::OFS_STATUS, {27'h0, uabr_pkg::ST_RST}, 32'hFFFF_FFFF);
      rdc(uabr_pkg::OFS_IRQ_MASK, 32'h0, 32'hFFFF_FFFF);
      rdc(5'h1C, 32'h0, 32'hFFFF_FFFF);
      cmp({31'h0, rx_xfer_req}, 32'h0);
      cmp({31'h0, irq}, 32'h0);
   endtask : chk_regs
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // watchdog: the whole sequence needs about 12000 cycles
   // ------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      uabr_row_t r;
      int        nb;
      rst = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      rx_xfer_ack = 1'b0;
      err_total = 0;
      n_tests = 0;
      // length, parity, data, bad parity, stop level, status, status mask
      rows = '{'{3'h3, 3'h0, 9'h0A5, 1'b0, 1'b1, 5'h01, 5'h1F}, '{3'h0, 3'h1, 9'h013, 1'b0, 1'b1, 5'h01, 5'h1F},
               '{3'h4, 3'h2, 9'h1C3, 1'b0, 1'b1, 5'h01, 5'h1F}, '{3'h2, 3'h3, 9'h055, 1'b0, 1'b1, 5'h01, 5'h1F},
               '{3'h1, 3'h4, 9'h02A, 1'b0, 1'b1, 5'h01, 5'h1F}, '{3'h3, 3'h0, 9'h0A5, 1'b1, 1'b1, 5'h05, 5'h1F},
               '{3'h3, 3'h4, 9'h081, 1'b0, 1'b0, 5'h09, 5'h1F}, '{3'h3, 3'h0, 9'h000, 1'b0, 1'b0, 5'h10, 5'h10}};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk_regs();
      // async from core clock, divisor 4: 64 core cycles a bit
      wr(uabr_pkg::OFS_DIVISOR, 32'h4);
      wr(uabr_pkg::OFS_IRQ_EN, 32'h1F);
      rdc(uabr_pkg::OFS_IRQ_MASK, 32'h1F, 32'hFFFF_FFFF);
      u_tx.low_pulse(20);
      repeat (200) @(posedge clk);
      cmp({31'h0, rx_xfer_req}, 32'h0);
      foreach (rows[i]) begin
         r = rows[i];
         nb = int'(r.len) + 5;
         wr(uabr_pkg::OFS_MODE, mode(r.len, r.par, 2'h0, 1'b0));
         u_tx.send(r.dat, nb, r.par, r.bad, r.stp, 64, 1'b0);
         wait_hi(1'b1);
         rdc(uabr_pkg::OFS_STATUS, {27'h0, r.st}, {27'h0, r.stm});
         rdc(uabr_pkg::OFS_HOLDING, {23'h0, r.dat},
             r.stm[uabr_pkg::ST_BRK_BIT] ? 32'h0 : ((32'h1 << nb) - 32'h1));
         repeat (3) @(posedge clk);
         cmp({31'h0, irq}, 32'h0);
      end
      // two characters unread: overrun, then the channel takes the second
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h4, 2'h0, 1'b0));
      u_tx.send(9'h03C, 8, 3'h4, 1'b0, 1'b1, 64, 1'b0);
      u_tx.send(9'h0C3, 8, 3'h4, 1'b0, 1'b1, 64, 1'b0);
      rdc(uabr_pkg::OFS_STATUS, 32'h3, 32'h1F);
      cmp({31'h0, rx_xfer_req}, 32'h1);
      cmp({23'h0, rx_xfer_data}, 32'h0C3);
      rx_xfer_ack <= 1'b1;
      @(posedge clk);
      rx_xfer_ack <= 1'b0;
      repeat (2) @(posedge clk);
      cmp({31'h0, rx_xfer_req}, 32'h0);
      // core over eight, divisor 1: 128 cycles a bit; ready masked at first
      wr(uabr_pkg::OFS_IRQ_DIS, 32'h1F);
      wr(uabr_pkg::OFS_IRQ_EN, 32'h02);
      wr(uabr_pkg::OFS_DIVISOR, 32'h1);
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h4, 2'h1, 1'b0));
      u_tx.send(9'h05A, 8, 3'h4, 1'b0, 1'b1, 128, 1'b0);
      wait_hi(1'b0);
      repeat (3) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      wr(uabr_pkg::OFS_IRQ_EN, 32'h01);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      rdc(uabr_pkg::OFS_IRQ_MASK, 32'h3, 32'hFFFF_FFFF);
      rdc(uabr_pkg::OFS_STATUS, 32'h1, 32'h1F);
      rdc(uabr_pkg::OFS_HOLDING, 32'h05A, 32'h1FF);
      // zero divisor: bit clock stopped, nothing received
      wr(uabr_pkg::OFS_DIVISOR, 32'h0);
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h4, 2'h0, 1'b0));
      u_tx.send(9'h0F0, 8, 3'h4, 1'b0, 1'b1, 64, 1'b0);
      cmp({31'h0, rx_xfer_req}, 32'h0);
      // synchronous, internal clock over 16
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h0, 2'h0, 1'b1));
      wr(uabr_pkg::OFS_DIVISOR, 32'h10);
      u_tx.send(9'h096, 8, 3'h0, 1'b0, 1'b1, 16, 1'b0);
      wait_hi(1'b0);
      rdc(uabr_pkg::OFS_STATUS, 32'h1, 32'h1F);
      rdc(uabr_pkg::OFS_HOLDING, 32'h096, 32'h1FF);
      // synchronous on the serial clock pin, divisor set to zero
      wr(uabr_pkg::OFS_DIVISOR, 32'h0);
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h0, 2'h2, 1'b1));
      u_tx.send(9'h069, 8, 3'h0, 1'b0, 1'b1, 8, 1'b1);
      wait_hi(1'b0);
      rdc(uabr_pkg::OFS_STATUS, 32'h1, 32'h1F);
      rdc(uabr_pkg::OFS_HOLDING, 32'h069, 32'h1FF);
      // reset in mid character
      wr(uabr_pkg::OFS_MODE, mode(3'h3, 3'h4, 2'h0, 1'b0));
      wr(uabr_pkg::OFS_DIVISOR, 32'h4);
      fork
         u_tx.send(9'h0FF, 8, 3'h4, 1'b0, 1'b1, 64, 1'b0);
         begin
            repeat (300) @(posedge clk);
            rst <= 1'b1;
            repeat (2) @(posedge clk);
            rst <= 1'b0;
         end
      join
      chk_regs();
      // after the reset the receiver hunts again: 5 bits, no parity
      wr(uabr_pkg::OFS_DIVISOR, 32'h4);
      u_tx.send(9'h015, 5, 3'h4, 1'b0, 1'b1, 64, 1'b0);
      wait_hi(1'b0);
      rdc(uabr_pkg::OFS_HOLDING, 32'h015, 32'h1FF);
      report_and_stop();
   end
endmodule : uabr_top_tb
